// ==== src/osc_trim_ctrl.sv ====
module osc_trim_ctrl #(
    parameter int CNT_W = 16
) (
    input  wire logic                             clk_i,
    input  wire logic                             rst_i,
    input  wire logic                             reg_wr_i,
    input  wire logic                             reg_rd_i,
    input  wire logic [trim_ctrl_pkg::ADDR_W-1:0] reg_addr_i,
    input  wire logic [31:0]                      reg_wdata_i,
    output logic      [31:0]                      reg_rdata_o,
    input  wire logic                             ext_sync_pin_i,
    input  wire logic                             low_speed_crystal_i,
    output logic      [5:0]                       osc_adjust_code_o,
    output logic                                  hw_tune_enable_o,
    output logic                                  tune_counter_enable_o,
    output logic      [3:0]                       irq_enable_o,
    output logic      [15:0]                      counter_value_o,
    output logic                                  count_down_o,
    output logic                                  good_flag_o,
    output logic                                  warn_flag_o,
    output logic                                  expect_ref_flag_o,
    output logic                                  clock_error_o,
    output logic                                  ref_miss_o,
    output logic                                  adjust_range_error_o
);
    import trim_ctrl_pkg::*;

    if (CNT_W != 16) begin : g_bad_width
        $error("counter width must be 16");
    end

    logic [5:0]       adj_reg;
    logic             hw_tune_reg;
    logic             cnt_en_reg;
    logic [3:0]       ie_reg;
    logic             soft_pulse_reg;
    logic [31:0]      refcfg_reg;
    logic             lvl_prev_reg;
    logic [6:0]       div_reg;
    logic             ext_pulse_reg;
    cnt_state_t       state_reg;
    logic [15:0]      count_reg;
    logic             wr_primary;
    logic             wr_refcfg;
    logic             sync_pulse;
    logic             src_lvl;
    logic             edge_hit;
    logic [6:0]       div_mask;
    logic [15:0]      lim1;
    logic [15:0]      lim3;
    logic [15:0]      lim128;
    logic [15:0]      preload;
    logic             evaluate;
    logic signed [2:0] delta;
    logic             ev_good;
    logic             ev_warn;
    logic             ev_err;
    logic [6:0]       sat_res;
    logic             adj_step;

    function automatic logic [6:0] sat_adjust(input logic [5:0] code,
                                              input logic signed [2:0] step);
        logic signed [7:0] sum;
        sum = $signed({2'b00, code}) + 8'(step);
        if (sum > $signed({2'b00, ADJ_MAX})) begin
            sat_adjust = {1'b1, ADJ_MAX};
        end else if (sum < 0) begin
            sat_adjust = {1'b1, 6'h00};
        end else begin
            sat_adjust = {1'b0, sum[5:0]};
        end
    endfunction

    assign wr_primary = reg_wr_i && (reg_addr_i == PRIMARY_OFS);
    assign wr_refcfg  = reg_wr_i && (reg_addr_i == REFCFG_OFS);
    assign preload    = refcfg_reg[PRELOAD_LSB +: 16];
    // evaluation thresholds from the tolerance base
    assign lim1   = {8'h00, refcfg_reg[TOL_LSB +: 8]};
    assign lim3   = 16'(refcfg_reg[TOL_LSB +: 8]) * 16'(WARN_MULT);
    assign lim128 = {1'b0, refcfg_reg[TOL_LSB +: 8], 7'h00};

    // primary control fields
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            hw_tune_reg <= PRIMARY_RESET[HW_TUNE_BIT];
            cnt_en_reg  <= PRIMARY_RESET[CNT_EN_BIT];
            ie_reg      <= PRIMARY_RESET[IE_LSB +: 4];
        end else if (wr_primary) begin
            hw_tune_reg <= reg_wdata_i[HW_TUNE_BIT];
            cnt_en_reg  <= reg_wdata_i[CNT_EN_BIT];
            ie_reg      <= reg_wdata_i[IE_LSB +: 4];
        end
    end

    // self-clearing software pulse
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            soft_pulse_reg <= 1'b0;
        end else begin
            soft_pulse_reg <= wr_primary && reg_wdata_i[SOFT_PULSE_BIT];
        end
    end

    // adjust code: hardware in auto mode, software otherwise
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            adj_reg <= PRIMARY_RESET[ADJ_LSB +: ADJ_W];
        end else if (hw_tune_reg) begin
            if (adj_step) begin
                adj_reg <= sat_res[5:0];
            end
        end else if (wr_primary) begin
            adj_reg <= reg_wdata_i[ADJ_LSB +: ADJ_W];
        end
    end

    // reference config, frozen while counting
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            refcfg_reg <= REFCFG_RESET;
        end else if (wr_refcfg && !cnt_en_reg) begin
            refcfg_reg <= (reg_wdata_i & REFCFG_WMASK) | (REFCFG_RESET & ~REFCFG_WMASK);
        end
    end

    // read data
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            reg_rdata_o <= 32'h0000_0000;
        end else if (reg_rd_i) begin
            unique case (reg_addr_i)
                PRIMARY_OFS: reg_rdata_o <= {18'h00000, adj_reg, 1'b0, hw_tune_reg,
                                             cnt_en_reg, 1'b0, ie_reg};
                REFCFG_OFS:  reg_rdata_o <= refcfg_reg;
                default:     reg_rdata_o <= 32'h0000_0000;
            endcase
        end
    end

    // reference source, edge, prescaler
    always_comb begin
        unique case (refcfg_reg[SRC_LSB +: 2])
            SRC_PIN:  src_lvl = ext_sync_pin_i;
            SRC_XTAL: src_lvl = low_speed_crystal_i;
            default:  src_lvl = 1'b0;
        endcase
    end
    assign edge_hit = refcfg_reg[EDGE_BIT] ? (lvl_prev_reg && !src_lvl)
                                           : (!lvl_prev_reg && src_lvl);
    assign div_mask = 7'h7f >> (3'h7 - refcfg_reg[DIV_LSB +: 3]);

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            lvl_prev_reg  <= 1'b0;
            div_reg       <= 7'h00;
            ext_pulse_reg <= 1'b0;
        end else begin
            lvl_prev_reg  <= src_lvl;
            ext_pulse_reg <= edge_hit && (div_reg == div_mask);
            if (edge_hit) begin
                div_reg <= (div_reg == div_mask) ? 7'h00 : div_reg + 7'h01;
            end
        end
    end

    assign sync_pulse = ext_pulse_reg | soft_pulse_reg;

    // trim counter
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            state_reg <= CNT_IDLE;
            count_reg <= 16'h0000;
        end else if (!cnt_en_reg) begin
            state_reg <= CNT_IDLE;
        end else if (sync_pulse) begin
            state_reg <= CNT_DOWN;
            count_reg <= preload;
        end else begin
            unique case (state_reg)
                CNT_IDLE: state_reg <= CNT_IDLE;
                CNT_DOWN: begin
                    if (count_reg == 16'h0000) begin
                        state_reg <= CNT_UP;
                        count_reg <= 16'h0001;
                    end else begin
                        count_reg <= count_reg - 16'h0001;
                    end
                end
                CNT_UP: begin
                    if (count_reg >= lim128) begin
                        state_reg <= CNT_HALT;
                    end else begin
                        count_reg <= count_reg + 16'h0001;
                    end
                end
                CNT_HALT: state_reg <= CNT_HALT;
            endcase
        end
    end

    // frequency evaluation at each pulse while counting down or up
    assign evaluate = cnt_en_reg && sync_pulse && (state_reg != CNT_IDLE);
    always_comb begin
        ev_good = 1'b0;
        ev_warn = 1'b0;
        ev_err  = 1'b0;
        delta   = 3'sd0;
        if (evaluate && state_reg != CNT_HALT) begin
            if (count_reg >= lim128) begin
                ev_err = (state_reg == CNT_DOWN);
            end else if (count_reg >= lim3) begin
                ev_warn = 1'b1;
                delta   = (state_reg == CNT_DOWN) ? 3'sd2 : -3'sd2;
            end else if (count_reg >= lim1) begin
                ev_good = 1'b1;
                delta   = (state_reg == CNT_DOWN) ? 3'sd1 : -3'sd1;
            end else begin
                ev_good = 1'b1;
            end
        end
    end
    assign sat_res  = sat_adjust(adj_reg, delta);
    assign adj_step = hw_tune_reg && (delta != 3'sd0);

    // event and status outputs
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            good_flag_o          <= 1'b0;
            warn_flag_o          <= 1'b0;
            clock_error_o        <= 1'b0;
            expect_ref_flag_o    <= 1'b0;
            ref_miss_o           <= 1'b0;
            adjust_range_error_o <= 1'b0;
        end else begin
            good_flag_o          <= ev_good;
            warn_flag_o          <= ev_warn;
            clock_error_o        <= ev_err;
            expect_ref_flag_o    <= cnt_en_reg && !sync_pulse && state_reg == CNT_DOWN
                                    && count_reg == 16'h0000;
            ref_miss_o           <= cnt_en_reg && !sync_pulse && state_reg == CNT_UP
                                    && count_reg >= lim128;
            adjust_range_error_o <= adj_step && sat_res[6];
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            osc_adjust_code_o     <= PRIMARY_RESET[ADJ_LSB +: ADJ_W];
            hw_tune_enable_o      <= 1'b0;
            tune_counter_enable_o <= 1'b0;
            irq_enable_o          <= 4'h0;
            counter_value_o       <= 16'h0000;
            count_down_o          <= 1'b0;
        end else begin
            osc_adjust_code_o     <= adj_reg;
            hw_tune_enable_o      <= hw_tune_reg;
            tune_counter_enable_o <= cnt_en_reg;
            irq_enable_o          <= ie_reg;
            counter_value_o       <= count_reg;
            count_down_o          <= (state_reg == CNT_DOWN);
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    pulse_reads_zero_a: assert property (reg_rd_i && reg_addr_i == PRIMARY_OFS
        |=> !reg_rdata_o[SOFT_PULSE_BIT]) else $error("soft pulse bit read back as one");
    pulse_single_a: assert property (soft_pulse_reg && !$past(soft_pulse_reg) ##0
        !wr_primary |=> !soft_pulse_reg) else $error("soft pulse lasted too long");
    manual_code_a: assert property (wr_primary && !hw_tune_reg
        |=> adj_reg == $past(reg_wdata_i[ADJ_LSB +: ADJ_W])) else $error("manual code lost");
    auto_lock_a: assert property (hw_tune_reg && !adj_step
        |=> $stable(adj_reg)) else $error("code changed without evaluation");
    cfg_locked_a: assert property (cnt_en_reg
        |=> $stable(refcfg_reg)) else $error("config changed while counting");
    range_sat_a: assert property (adjust_range_error_o
        |-> adj_reg == 6'h00 || adj_reg == ADJ_MAX)
        else $error("range error with unsaturated code");
    preload_soft_a: assert property (soft_pulse_reg && cnt_en_reg
        |=> count_reg == $past(preload) && state_reg == CNT_DOWN)
        else $error("soft pulse did not reload");
    halt_hold_a: assert property (state_reg == CNT_HALT && !sync_pulse && cnt_en_reg
        |=> $stable(count_reg) ##0 state_reg == CNT_HALT) else $error("halted counter moved");
    warn_step_a: assert property (ev_warn && hw_tune_reg && state_reg == CNT_DOWN
        && adj_reg < 6'h3e |=> adj_reg == $past(adj_reg) + 6'h02)
        else $error("warning band step wrong");

    warn_seen_c: cover property (warn_flag_o);
    miss_seen_c: cover property (ref_miss_o);
    range_seen_c: cover property (adjust_range_error_o);
    auto_step_c: cover property (adj_step ##1 good_flag_o);
endmodule

// ==== src/trim_ctrl_pkg.sv ====
package trim_ctrl_pkg;
    localparam int          ADDR_W        = 8;
    localparam logic [7:0]  PRIMARY_OFS   = 8'h00;
    localparam logic [7:0]  REFCFG_OFS    = 8'h04;
    localparam logic [31:0] PRIMARY_RESET = 32'h0000_2000;
    localparam logic [31:0] REFCFG_RESET  = 32'h2022_bb7f;
    localparam logic [31:0] REFCFG_WMASK  = 32'hb7ff_ffff;
    localparam int          ADJ_LSB       = 8;
    localparam int          ADJ_W         = 6;
    localparam int          SOFT_PULSE_BIT = 7;
    localparam int          HW_TUNE_BIT   = 6;
    localparam int          CNT_EN_BIT    = 5;
    localparam int          IE_LSB        = 0;
    localparam int          EDGE_BIT      = 31;
    localparam int          SRC_LSB       = 28;
    localparam int          DIV_LSB       = 24;
    localparam int          TOL_LSB       = 16;
    localparam int          PRELOAD_LSB   = 0;
    localparam logic [5:0]  ADJ_MID       = 6'h20;
    localparam logic [5:0]  ADJ_MAX       = 6'h3f;
    localparam int          STEP_KHZ      = 57;
    localparam logic [1:0]  SRC_PIN       = 2'h0;
    localparam logic [1:0]  SRC_XTAL      = 2'h1;
    localparam int          UP_SHIFT      = 7;
    localparam logic [1:0]  WARN_MULT     = 2'h3;
    typedef enum logic [1:0] {CNT_IDLE, CNT_DOWN, CNT_UP, CNT_HALT} cnt_state_t;
endpackage

// ==== tb/ref_source_model.sv ====
module ref_source_model (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_en_i,
    input  wire logic xtal_en_i,
    output logic      sync_pin_o,
    output logic      crystal_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] phase_reg;
    // period of 24 clocks; both lines idle low while stopped
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            phase_reg  <= 5'h00;
            sync_pin_o <= 1'b0;
            crystal_o  <= 1'b0;
        end else if (!(pin_en_i || xtal_en_i)) begin
            phase_reg  <= 5'h00;
            sync_pin_o <= 1'b0;
            crystal_o  <= 1'b0;
        end else begin
            phase_reg  <= (phase_reg == 5'h17) ? 5'h00 : phase_reg + 5'h01;
            sync_pin_o <= pin_en_i && (phase_reg < 5'h08);
            crystal_o  <= xtal_en_i && (phase_reg < 5'h0c);
        end
    end
endmodule

// ==== tb/testbench.sv ====
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import trim_ctrl_pkg::*;
    typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] r;} row_t;
    typedef struct {logic [31:0] cfg; logic pin; logic xtal; int lo; int hi;} ext_t;
    logic              clk_i       = 1'b0;
    logic              rst_i       = 1'b1;
    logic              reg_wr_i    = 1'b0;
    logic              reg_rd_i    = 1'b0;
    logic [ADDR_W-1:0] reg_addr_i  = '0;
    logic [31:0]       reg_wdata_i = '0;
    logic              pin_en      = 1'b0;
    logic              xtal_en     = 1'b0;
    logic [31:0]       reg_rdata_o;
    logic [31:0]       rdat;
    logic              sync_pin;
    logic              crystal;
    logic [5:0]        code_o;
    logic              hw_en_o;
    logic              cnt_en_o;
    logic              down_o;
    logic [3:0]        ie_o;
    logic [15:0]       cnt_o;
    logic              good_o;
    logic              warn_o;
    logic              exp_o;
    logic              err_o;
    logic              miss_o;
    logic              rng_o;
    int                n_errors    = 0;
    int                n_checks    = 0;
    int                base;
    int                ev [6]      = '{default: 0};
    row_t rows [7] = '{
        '{8'h00, 32'h0000_150f, 32'h0000_150f}, '{8'h00, 32'h0000_3f00, 32'h0000_3f00},
        '{8'h00, 32'h0000_0000, 32'h0000_0000}, '{8'h00, 32'h0000_0080, 32'h0000_0000},
        '{8'h04, 32'h9123_4567, 32'h9123_4567}, '{8'h04, 32'hb7ff_ffff, 32'hb7ff_ffff},
        '{8'h08, 32'h0000_1234, 32'h0000_0000}};
    ext_t ext [6] = '{
        '{32'h0001_0040, 1'b1, 1'b0, 14, 16}, '{32'h1001_0040, 1'b0, 1'b1, 14, 16},
        '{32'h9001_0040, 1'b0, 1'b1, 14, 16}, '{32'h0201_0040, 1'b1, 1'b0, 2, 4},
        '{32'h0701_0040, 1'b1, 1'b0, 0, 0}, '{32'h2001_0040, 1'b1, 1'b1, 0, 0}};

    osc_trim_ctrl #(.CNT_W(16)) osc_trim_ctrl_inst (
        .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .ext_sync_pin_i(sync_pin), .low_speed_crystal_i(crystal),
        .osc_adjust_code_o(code_o), .hw_tune_enable_o(hw_en_o),
        .tune_counter_enable_o(cnt_en_o), .irq_enable_o(ie_o), .counter_value_o(cnt_o),
        .count_down_o(down_o), .good_flag_o(good_o), .warn_flag_o(warn_o),
        .expect_ref_flag_o(exp_o), .clock_error_o(err_o), .ref_miss_o(miss_o),
        .adjust_range_error_o(rng_o));
    ref_source_model ref_source_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .pin_en_i(pin_en), .xtal_en_i(xtal_en),
        .sync_pin_o(sync_pin), .crystal_o(crystal));

    always #2 clk_i = ~clk_i;

    // tallies: evaluations, expect-ref, miss, range errors, clock errors, warnings
    always @(negedge clk_i) begin
        if (rst_i === 1'b0) begin
            if (good_o === 1'b1 || warn_o === 1'b1 || err_o === 1'b1) ev[0]++;
            if (exp_o === 1'b1) ev[1]++;
            if (miss_o === 1'b1) ev[2]++;
            if (rng_o === 1'b1) ev[3]++;
            if (err_o === 1'b1) ev[4]++;
            if (warn_o === 1'b1) ev[5]++;
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        reg_wr_i    <= 1'b1;
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        @(posedge clk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge clk_i);
        reg_rd_i   <= 1'b1;
        reg_addr_i <= a;
        @(posedge clk_i);
        reg_rd_i   <= 1'b0;
        @(posedge clk_i);
        @(negedge clk_i);
        rdat = reg_rdata_o;
    endtask

    // two back-to-back soft pulses: second evaluates at preload minus one
    task automatic band_case(input logic [31:0] cfg, input logic [31:0] exp);
        wr(8'h00, 32'h0000_0000);
        wr(8'h04, cfg);
        wr(8'h00, 32'h0000_2060);
        wr(8'h00, 32'h0000_20e0);
        wr(8'h00, 32'h0000_20e0);
        rd(8'h00);
        chk_word(rdat, exp);
    endtask

    task automatic wait_ev(input int k, input int tgt, input int lim);
        for (int i = 0; i < lim && ev[k] < tgt; i++) begin
            @(posedge clk_i);
        end
        if (ev[k] < tgt) begin
            n_errors++;
            $display("Error at %0t: got %h expected %h", $time, ev[k], tgt);
            finish_test();
        end
    endtask

    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].w);
            rd(rows[i].a);
            chk_word(rdat, rows[i].r);
        end
        $display("test register table done");
        wr(8'h04, 32'h0001_0040);
        wr(8'h00, 32'h0000_202a);
        wr(8'h04, 32'h1234_5678);
        rd(8'h04);
        chk_word(rdat, 32'h0001_0040);
        chk_word({28'h0, ie_o}, 32'h0000_000a);
        chk_word({31'h0, cnt_en_o}, 32'h1);
        wr(8'h00, 32'h0000_20a0);
        wait_ev(1, ev[1] + 1, 100);
        wait_ev(2, ev[2] + 1, 200);
        repeat (4) @(posedge clk_i);
        chk_word({16'h0, cnt_o}, 32'h0000_0080);
        base = ev[0];
        wr(8'h00, 32'h0000_20a0);
        repeat (4) @(posedge clk_i);
        chk_word(ev[0] - base, 32'h0);
        chk_word({31'h0, down_o && cnt_o <= 16'h0040 && cnt_o >= 16'h003a}, 32'h1);
        $display("test lock and count done");
        wr(8'h00, 32'h0000_2000);
        wr(8'h00, 32'h0000_2060);
        wr(8'h00, 32'h0000_20e0);
        wr(8'h00, 32'h0000_05e0);
        rd(8'h00);
        chk_word(rdat, 32'h0000_2260);
        chk_word({31'h0, hw_en_o}, 32'h1);
        wr(8'h00, 32'h0000_3e00);
        wr(8'h00, 32'h0000_3e60);
        wr(8'h00, 32'h0000_3ee0);
        wr(8'h00, 32'h0000_3ee0);
        rd(8'h00);
        chk_word(rdat, 32'h0000_3f60);
        wr(8'h00, 32'h0000_0100);
        wr(8'h00, 32'h0000_0160);
        wr(8'h00, 32'h0000_01e0);
        wait_ev(1, ev[1] + 1, 100);
        repeat (8) @(posedge clk_i);
        wr(8'h00, 32'h0000_01e0);
        rd(8'h00);
        chk_word(rdat, 32'h0000_0060);
        chk_word(ev[3], 32'h2);
        $display("test automatic trim done");
        band_case(32'h0010_0020, 32'h0000_2160);
        band_case(32'h0010_0008, 32'h0000_2060);
        band_case(32'h0010_0900, 32'h0000_2060);
        chk_word(ev[4], 32'h1);
        chk_word(ev[5], 32'h3);
        $display("test evaluation bands done");
        foreach (ext[i]) begin
            wr(8'h00, 32'h0000_0000);
            wr(8'h04, ext[i].cfg);
            wr(8'h00, 32'h0000_0020);
            base = ev[0];
            pin_en  <= ext[i].pin;
            xtal_en <= ext[i].xtal;
            repeat (384) @(posedge clk_i);
            pin_en  <= 1'b0;
            xtal_en <= 1'b0;
            repeat (4) @(posedge clk_i);
            chk_word({31'h0, ev[0] - base >= ext[i].lo && ev[0] - base <= ext[i].hi},
                     32'h1);
        end
        $display("test reference sources done");
        wr(8'h00, 32'h0000_1560);
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        rd(8'h00);
        chk_word(rdat, 32'h0000_2000);
        rd(8'h04);
        chk_word(rdat, 32'h2022_bb7f);
        chk_word({26'h0, code_o}, 32'h0000_0020);
        $display("test reset done");
        finish_test();
    end
endmodule
